// ---- verilog/port_pkg.sv ----
// constants and types shared by the bidirectional port pin block
//------------------------------------------------------------
// Functional notes
// - unused upper register bits read as zero
// - port latches kept across non-power-on resets
// - wake flag set only for pin-change wake reset
// - bit set/clear reads pins, rewrites whole port
// - input pins copy their level into latches on bit set/clear
// - port writes land at end of cycle
// - port reads sample pins at cycle start
// - direction one floats pin, zero drives latch
// - port reads return pins, not latches
// - direction write-only, loaded by instruction, reset ones
//------------------------------------------------------------
package port_pkg;
	localparam int PORT_W = 6;
	localparam int NPORT = 2;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h03;
	localparam logic [ADDR_W-1:0] ADDR_FIRST = 5'h06;
	localparam logic [ADDR_W-1:0] ADDR_SECOND = 5'h07;
	localparam int WAKE_FLAG_BIT = 7;
	localparam int WAKE_DIS_BIT = 7;
	localparam int PULLUP_DIS_BIT = 6;
	localparam logic [PORT_W-1:0] DIR_RESET = 6'h3f;
	localparam logic [DATA_W-1:0] OPTION_RESET = 8'hff;
	// power-on value is undefined in the part; zero is one legal choice
	localparam logic [PORT_W-1:0] LATCH_POR = 6'h00;
	localparam logic [DATA_W-PORT_W-1:0] UPPER_ZERO = 2'h0;
	localparam logic [WAKE_FLAG_BIT-1:0] STATUS_LOW_ZERO = 7'h00;

	// four clock phases make one instruction cycle
	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_READ,
		OP_WRITE,
		OP_BSET,
		OP_BCLR,
		OP_DIR,
		OP_OPT
	} op_t;

	typedef struct packed {
		op_t op;
		logic [ADDR_W-1:0] addr;
		logic [2:0] bit_sel;
		logic [DATA_W-1:0] wdata;
	} core_req_t;

	typedef logic [NPORT-1:0][PORT_W-1:0] port_vec_t;
endpackage

// ---- verilog/bidirectional_port_pins.sv ----
// port pin block: output latches, direction control, pin sampling, wake flag
`timescale 1ns/1ns
module bidirectional_port_pins
	import port_pkg::*;
(
	input wire logic clk, // 50 MHz core clock
	input wire logic arst_n, // power-on reset, async
	input wire logic sys_reset, // any other reset, one-cycle pulse
	input wire logic wake_cause, // that reset came from pin-change wake
	input wire core_req_t req, // core access, held for a whole cycle
	output logic cycle_start, // first phase of an instruction cycle
	output logic [DATA_W-1:0] rd_data, // read value, valid from phase two
	input wire port_vec_t pin_in, // pad levels
	output port_vec_t pin_out, // pad drive values
	output port_vec_t pin_oe, // pad drive enables, high = driving
	output logic wake_on_change_disable, // option bit, high = off
	output logic weak_pullup_disable // option bit, high = off
);

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	function automatic logic port_hit(input logic [ADDR_W-1:0] a);
		return (a == ADDR_FIRST) || (a == ADDR_SECOND);
	endfunction

	function automatic logic port_idx(input logic [ADDR_W-1:0] a);
		return a == ADDR_SECOND;
	endfunction

	function automatic logic [PORT_W-1:0] bit_apply(
		input logic [PORT_W-1:0] v,
		input logic [2:0] b,
		input logic set
	);
		logic [PORT_W-1:0] r;
		r = v;
		for (int i = 0; i < PORT_W; i++) begin
			if (b == 3'(i)) begin
				r[i] = set;
			end
		end
		return r;
	endfunction

	//------------------------------------------------------------
	// instruction phase sequencer
	//------------------------------------------------------------
	phase_t phase_q, phase_d;

	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			PH_Q1: phase_d = PH_Q2;
			PH_Q2: phase_d = PH_Q3;
			PH_Q3: phase_d = PH_Q4;
			PH_Q4: phase_d = PH_Q1;
		endcase
		if (sys_reset) begin
			phase_d = PH_Q1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= PH_Q1;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign cycle_start = (phase_q == PH_Q1);

	//------------------------------------------------------------
	// pin synchroniser
	//------------------------------------------------------------
	port_vec_t sync1_q, sync2_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	//------------------------------------------------------------
	// start of cycle: take request, sample pins, form read data
	//------------------------------------------------------------
	core_req_t req_q, req_d;
	port_vec_t sample_q, sample_d;
	logic [DATA_W-1:0] rd_q, rd_d;
	logic wake_q, wake_d;

	always_comb begin
		req_d = req_q;
		sample_d = sample_q;
		rd_d = rd_q;
		if (cycle_start) begin
			req_d = req;
			sample_d = sync2_q;
			rd_d = '0;
			if (port_hit(req.addr)) begin
				rd_d = {UPPER_ZERO, sync2_q[port_idx(req.addr)]};
			end else if (req.addr == ADDR_STATUS) begin
				rd_d = {wake_q, STATUS_LOW_ZERO};
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			req_q <= '0;
			sample_q <= '0;
			rd_q <= '0;
		end else begin
			req_q <= req_d;
			sample_q <= sample_d;
			rd_q <= rd_d;
		end
	end

	assign rd_data = rd_q;

	//------------------------------------------------------------
	// end of cycle: latches, direction, option; wake flag loaded only at reset
	//------------------------------------------------------------
	port_vec_t latch_q, latch_d;
	port_vec_t dir_q, dir_d;
	logic [DATA_W-1:0] option_q, option_d;
	logic last_phase;
	logic hit_q;
	logic idx_q;

	assign last_phase = (phase_q == PH_Q4);
	assign hit_q = port_hit(req_q.addr);
	assign idx_q = port_idx(req_q.addr);

	always_comb begin
		latch_d = latch_q;
		dir_d = dir_q;
		option_d = option_q;
		wake_d = wake_q;
		if (sys_reset) begin
			dir_d = {NPORT{DIR_RESET}};
			option_d = OPTION_RESET;
			wake_d = wake_cause;
		end else if (last_phase) begin
			unique case (req_q.op)
				OP_WRITE: begin
					if (hit_q) begin
						latch_d[idx_q] = req_q.wdata[PORT_W-1:0];
					end
				end
				OP_BSET, OP_BCLR: begin
					if (hit_q) begin
						// whole port from pins, selected bit changed; bit_sel 6 or 7 changes none
						latch_d[idx_q] = bit_apply(sample_q[idx_q], req_q.bit_sel,
							req_q.op == OP_BSET);
					end
				end
				OP_DIR: begin
					if (hit_q) begin
						dir_d[idx_q] = req_q.wdata[PORT_W-1:0];
					end
				end
				OP_OPT: option_d = req_q.wdata;
				OP_NONE, OP_READ: ;
				default: ;
			endcase
		end
	end

	// latches have no reset value beyond power-on
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			latch_q <= {NPORT{LATCH_POR}};
			dir_q <= {NPORT{DIR_RESET}};
			option_q <= OPTION_RESET;
			wake_q <= 1'b0;
		end else begin
			latch_q <= latch_d;
			dir_q <= dir_d;
			option_q <= option_d;
			wake_q <= wake_d;
		end
	end

	//------------------------------------------------------------
	// pad drive
	//------------------------------------------------------------
	assign pin_out = latch_q;
	assign pin_oe = ~dir_q;
	assign wake_on_change_disable = option_q[WAKE_DIS_BIT];
	assign weak_pullup_disable = option_q[PULLUP_DIS_BIT];

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_latch_end_only: assert property (
		!last_phase |=> $stable(latch_q))
		else $error("port latch changed before end of cycle");

	a_write_lands: assert property (
		last_phase && !sys_reset && req_q.op == OP_WRITE && req_q.addr == ADDR_FIRST
		|=> pin_out[0] == $past(req_q.wdata[PORT_W-1:0]))
		else $error("port write did not land at end of cycle");

	a_bit_rmw: assert property (
		last_phase && !sys_reset && req_q.op == OP_BSET && req_q.addr == ADDR_SECOND
		&& req_q.bit_sel < 3'h6
		|=> pin_out[1] == ($past(sample_q[1]) | (6'h01 << $past(req_q.bit_sel))))
		else $error("bit set did not rewrite whole port from pins");

	a_input_copied: assert property (
		last_phase && !sys_reset && (req_q.op == OP_BSET || req_q.op == OP_BCLR)
		&& req_q.addr == ADDR_FIRST
		|=> ((pin_out[0] ^ $past(sample_q[0])) & dir_q[0]
		& ~(6'h01 << $past(req_q.bit_sel))) == '0)
		else $error("input pin level not copied into latch");

	a_read_pins: assert property (
		cycle_start && !sys_reset && req.addr == ADDR_FIRST
		|=> rd_data == {UPPER_ZERO, $past(sync2_q[0])})
		else $error("port read did not return sampled pins");

	a_read_held: assert property (
		cycle_start && !sys_reset ##1 !cycle_start [*3]
		|-> $stable(rd_data))
		else $error("read data moved inside the cycle");

	a_upper_zero: assert property (
		cycle_start && port_hit(req.addr)
		|=> rd_data[DATA_W-1:PORT_W] == UPPER_ZERO)
		else $error("unused port bits not read as zero");

	a_status_low: assert property (
		rd_data[WAKE_FLAG_BIT-1:0] != STATUS_LOW_ZERO
		|-> $past(port_hit(req.addr)))
		else $error("status low bits not zero");

	a_keep_latch: assert property (
		sys_reset |=> $stable(latch_q))
		else $error("port latch changed by non-power-on reset");

	a_dir_reset: assert property (
		sys_reset |=> pin_oe == '0 ##1 (pin_oe == '0) [*3])
		else $error("drivers not released after reset");

	a_wake_flag: assert property (
		sys_reset |=> wake_q == $past(wake_cause))
		else $error("wake flag does not match reset cause");

	a_oe_follows_dir: assert property (
		last_phase && !sys_reset && req_q.op == OP_DIR && req_q.addr == ADDR_SECOND
		|=> pin_oe[1] == ~$past(req_q.wdata[PORT_W-1:0]))
		else $error("driver enable does not follow direction write");

	a_unmapped_zero: assert property (
		cycle_start && !sys_reset && !port_hit(req.addr) && req.addr != ADDR_STATUS
		|=> rd_data == '0)
		else $error("unmapped address did not read zero");

	a_bit_clear: assert property (
		last_phase && !sys_reset && req_q.op == OP_BCLR && req_q.addr == ADDR_FIRST
		&& req_q.bit_sel < 3'h6
		|=> pin_out[0] == ($past(sample_q[0]) & ~(6'h01 << $past(req_q.bit_sel))))
		else $error("bit clear did not rewrite whole port from pins");

	a_dir_only_op: assert property (
		!sys_reset && !(last_phase && req_q.op == OP_DIR) |=> $stable(pin_oe))
		else $error("driver enables changed without a direction write");

	a_sample_start: assert property (
		cycle_start |=> sample_q == $past(sync2_q))
		else $error("pins not sampled at cycle start");

	a_wake_kept: assert property (
		!sys_reset |=> $stable(wake_q))
		else $error("wake flag changed outside a reset");

	a_status_read: assert property (
		cycle_start && !sys_reset && req.addr == ADDR_STATUS
		|=> rd_data == {$past(wake_q), STATUS_LOW_ZERO})
		else $error("status read does not show the wake flag");

	c_bit_set: cover property (
		last_phase && req_q.op == OP_BSET && hit_q);

	c_write_then_read: cover property (
		last_phase && req_q.op == OP_WRITE && hit_q ##1 cycle_start && req.op == OP_READ);

	c_wake_reset: cover property (
		sys_reset && wake_cause);

	c_bit_clear: cover property (
		last_phase && req_q.op == OP_BCLR && hit_q);

	c_status_read: cover property (
		cycle_start && req.op == OP_READ && req.addr == ADDR_STATUS && wake_q);

endmodule

// ---- dv/pin_world.sv ----
// outside circuitry that drives or senses the port pins
`timescale 1ns/1ns
module pin_world
	import port_pkg::*;
(
	input wire port_vec_t pin_out, // block drive values
	input wire port_vec_t pin_oe, // block drive enables
	input wire port_vec_t ext, // levels forced by outside circuits
	output port_vec_t pin_in // resolved pad levels
);
	//------------------------------------------------------------
	// pad resolution
	//------------------------------------------------------------
	// outside circuits only act on pins whose driver is off
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the bidirectional port pin block
`timescale 1ns/1ns
module testbench;
	import port_pkg::*;
	logic clk = 0, arst_n = 0, sys_reset = 0, wake_cause = 0;
	core_req_t req = '0;
	logic cycle_start, wdis, pdis;
	logic [DATA_W-1:0] rd_data, rv, mid;
	port_vec_t pin_in, pin_out, pin_oe;
	port_vec_t ext = '0;
	int num_errors = 0;
	int comparisons = 0;
	always #10 clk = ~clk;
	bidirectional_port_pins dut(.clk(clk), .arst_n(arst_n), .sys_reset(sys_reset),
		.wake_cause(wake_cause), .req(req), .cycle_start(cycle_start), .rd_data(rd_data),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.wake_on_change_disable(wdis), .weak_pullup_disable(pdis));
	pin_world world(.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
	//------------------------------------------------------------
	// tasks
	//------------------------------------------------------------
	task results;
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			num_errors++;
		end
	endtask
	task wait_q1;
		int i;
		for (i = 0; i < 8 && cycle_start !== 1'b1; i++) @(negedge clk);
		if (i == 8) begin
			num_errors++;
			results();
		end
	endtask
	// one instruction cycle; returns at the next cycle start with effects landed
	task op(input op_t o, input logic [4:0] a, input logic [2:0] b, input logic [7:0] w);
		wait_q1();
		req = '{o, a, b, w};
		@(negedge clk);
		rv = rd_data;
		mid = {2'h0, pin_out[0]};
		wait_q1();
	endtask
	task sreset(input logic w);
		wake_cause = w;
		sys_reset = 1;
		@(negedge clk);
		sys_reset = 0;
	endtask
	//------------------------------------------------------------
	// sequence
	//------------------------------------------------------------
	initial begin
		repeat (20) @(negedge clk);
		arst_n = 1;
		op(OP_READ, ADDR_STATUS, 0, 0);
		chk("status", rv, 8'h00);
		op(OP_READ, 5'h05, 0, 0);
		chk("unmapped", rv, 8'h00);
		op(OP_DIR, ADDR_FIRST, 0, 8'hf0);
		chk("oe0", {2'h0, pin_oe[0]}, 8'h0f);
		chk("oe1", {2'h0, pin_oe[1]}, 8'h00);
		op(OP_WRITE, ADDR_FIRST, 0, 8'hea);
		chk("mid", mid, 8'h00);
		chk("out0", {2'h0, pin_out[0]}, 8'h2a);
		op(OP_READ, ADDR_FIRST, 0, 0);
		chk("early read", rv, 8'h00);
		ext[0] = 6'h10;
		op(OP_NONE, 0, 0, 0);
		op(OP_READ, ADDR_FIRST, 0, 0);
		chk("read0", rv, 8'h1a);
		op(OP_BSET, ADDR_FIRST, 0, 0);
		chk("bset", {2'h0, pin_out[0]}, 8'h1b);
		op(OP_NONE, 0, 0, 0);
		op(OP_BCLR, ADDR_FIRST, 6, 0);
		chk("bclr6", {2'h0, pin_out[0]}, 8'h1b);
		op(OP_BCLR, ADDR_FIRST, 1, 0);
		chk("bclr1", {2'h0, pin_out[0]}, 8'h19);
		op(OP_DIR, ADDR_SECOND, 0, 8'h00);
		chk("oe1 out", {2'h0, pin_oe[1]}, 8'h3f);
		op(OP_WRITE, ADDR_SECOND, 0, 8'h15);
		op(OP_NONE, 0, 0, 0);
		op(OP_READ, ADDR_SECOND, 0, 0);
		chk("read1", rv, 8'h15);
		op(OP_BSET, ADDR_SECOND, 3, 0);
		chk("bset1", {2'h0, pin_out[1]}, 8'h1d);
		op(OP_OPT, 0, 0, 8'h3f);
		chk("opt a", {6'h0, wdis, pdis}, 8'h00);
		op(OP_OPT, 0, 0, 8'hbf);
		chk("opt b", {6'h0, wdis, pdis}, 8'h02);
		op(OP_NONE, 0, 0, 0);
		sreset(1);
		wait_q1();
		chk("kept0", {2'h0, pin_out[0]}, 8'h19);
		chk("kept1", {2'h0, pin_out[1]}, 8'h1d);
		chk("oe reset", {2'h0, pin_oe[0] | pin_oe[1]}, 8'h00);
		chk("opt reset", {6'h0, wdis, pdis}, 8'h03);
		op(OP_READ, ADDR_STATUS, 0, 0);
		chk("wake", rv, 8'h80);
		op(OP_NONE, 0, 0, 0);
		sreset(0);
		op(OP_READ, ADDR_STATUS, 0, 0);
		chk("no wake", rv, 8'h00);
		results();
	end
endmodule
